// ==== common/twc_pkg.sv ====
package twc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h04;
    localparam logic [7:0] ADDR_COUNT = 8'h08;
    localparam logic [7:0] ADDR_CMP_A = 8'h0C;
    localparam logic [7:0] ADDR_CMP_B = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int MODE_HI_BIT = 3;
    localparam int FORCE_A_BIT = 7;
    localparam int FORCE_B_BIT = 6;
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    localparam logic [7:0] CTRL_B_RMASK = 8'h0F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] VAL_MAX = 8'hFF;
    localparam logic [7:0] VAL_BOTTOM = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // prescaler divide ratios
    // ------------------------------------------------------------
    localparam int DIV_8 = 8;
    localparam int DIV_32 = 32;
    localparam int DIV_64 = 64;
    localparam int DIV_128 = 128;
    localparam int DIV_256 = 256;
    localparam int DIV_1024 = 1024;

    typedef enum logic [2:0] {
        TWC_NORMAL = 3'h0,
        TWC_PC_FF = 3'h1,
        TWC_CTC = 3'h2,
        TWC_FAST_FF = 3'h3,
        TWC_RES4 = 3'h4,
        TWC_PC_TOPA = 3'h5,
        TWC_RES6 = 3'h6,
        TWC_FAST_TOPA = 3'h7
    } twc_mode_type;

    typedef struct packed {
        logic [1:0] output_a_action;
        logic [1:0] output_b_action;
        logic [2:0] waveform_mode;
        logic [2:0] clock_select_field;
    } twc_cfg_type;

    typedef struct packed {
        logic overflow;
        logic match_a;
        logic match_b;
    } twc_evt_type;

endpackage : twc_pkg

// ==== rtl/twc_timer8.sv ====
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module twc_timer8 (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_compare_output_a,
    output logic o_pin_override_a,
    output logic o_compare_output_b,
    output logic o_pin_override_b,
    output twc_pkg::twc_evt_type o_events
);
    import twc_pkg::*;

    // ------------------------------------------------------------
    // reset synchroniser
    // ------------------------------------------------------------
    logic rst_meta_q, rst_n_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_a_q, ctrl_b_q, count_q, cmp_a_q, cmp_b_q, buf_a_q, buf_b_q;
    logic dir_down_q, block_q;
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    twc_cfg_type cfg;
    twc_mode_type mode;

    assign cfg.output_a_action = ctrl_a_q[ACT_A_LSB +: 2];
    assign cfg.output_b_action = ctrl_a_q[ACT_B_LSB +: 2];
    assign cfg.waveform_mode = {ctrl_b_q[MODE_HI_BIT], ctrl_a_q[1:0]};
    assign cfg.clock_select_field = ctrl_b_q[2:0];
    assign mode = twc_mode_type'(cfg.waveform_mode);

    function automatic logic is_phase(input twc_mode_type m);
        return (m == TWC_PC_FF) || (m == TWC_PC_TOPA);
    endfunction : is_phase

    function automatic logic is_fast(input twc_mode_type m);
        return (m == TWC_FAST_FF) || (m == TWC_FAST_TOPA);
    endfunction : is_fast

    logic pwm;
    assign pwm = is_phase(mode) || is_fast(mode);

    // ------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------
    logic do_write;
    assign do_write = aw_q && w_q && !o_bvalid;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (do_write) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_q <= ADDR_CMP_B && awaddr_q[1:0] == 2'h0) ?
                           RESP_OKAY : RESP_SLVERR;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    logic wr_ca, wr_cb, wr_cnt, wr_oa, wr_ob;
    assign wr_ca = do_write && wstrb_q[0] && awaddr_q == ADDR_CTRL_A;
    assign wr_cb = do_write && wstrb_q[0] && awaddr_q == ADDR_CTRL_B;
    assign wr_cnt = do_write && wstrb_q[0] && awaddr_q == ADDR_COUNT;
    assign wr_oa = do_write && wstrb_q[0] && awaddr_q == ADDR_CMP_A;
    assign wr_ob = do_write && wstrb_q[0] && awaddr_q == ADDR_CMP_B;

    // force strobes are one-cycle and never stored; ignored in pwm modes
    logic force_a, force_b;
    assign force_a = wr_cb && wdata_q[FORCE_A_BIT] && !pwm;
    assign force_b = wr_cb && wdata_q[FORCE_B_BIT] && !pwm;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_a_q <= RESET_BYTE;
            ctrl_b_q <= RESET_BYTE;
            buf_a_q <= RESET_BYTE;
            buf_b_q <= RESET_BYTE;
        end else begin
            if (wr_ca) ctrl_a_q <= wdata_q[7:0] & CTRL_A_WMASK;
            if (wr_cb) ctrl_b_q <= wdata_q[7:0] & CTRL_B_RMASK;
            if (wr_oa) buf_a_q <= wdata_q[7:0];
            if (wr_ob) buf_b_q <= wdata_q[7:0];
        end
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [9:0] pre_q;
    logic tick;
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) pre_q <= 10'h000;
        else pre_q <= pre_q + 10'h001;
    end

    function automatic logic div_hit(input logic [9:0] p, input int d);
        return (p & 10'((d - 1))) == 10'((d - 1));
    endfunction : div_hit

    always_comb begin
        case (cfg.clock_select_field)
            3'h0: tick = 1'b0;
            3'h1: tick = 1'b1;
            3'h2: tick = div_hit(pre_q, DIV_8);
            3'h3: tick = div_hit(pre_q, DIV_32);
            3'h4: tick = div_hit(pre_q, DIV_64);
            3'h5: tick = div_hit(pre_q, DIV_128);
            3'h6: tick = div_hit(pre_q, DIV_256);
            default: tick = div_hit(pre_q, DIV_1024);
        endcase
    end

    // ------------------------------------------------------------
    // counter, top, matches
    // ------------------------------------------------------------
    logic [7:0] top;
    always_comb begin
        case (mode)
            TWC_CTC, TWC_PC_TOPA, TWC_FAST_TOPA: top = cmp_a_q;
            default: top = VAL_MAX;
        endcase
    end

    logic at_top, at_bot, m_a, m_b;
    assign at_top = count_q == top;
    assign at_bot = count_q == VAL_BOTTOM;
    assign m_a = tick && !block_q && count_q == cmp_a_q;
    assign m_b = tick && !block_q && count_q == cmp_b_q;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q <= RESET_BYTE;
            dir_down_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            if (wr_cnt) begin
                count_q <= wdata_q[7:0];
                block_q <= 1'b1;
            end else if (tick) begin
                block_q <= 1'b0;
                if (is_phase(mode)) begin
                    if (!dir_down_q && at_top) begin
                        dir_down_q <= 1'b1;
                        count_q <= count_q - 8'h01;
                    end else if (dir_down_q && at_bot) begin
                        dir_down_q <= 1'b0;
                        count_q <= count_q + 8'h01;
                    end else begin
                        count_q <= dir_down_q ? count_q - 8'h01 : count_q + 8'h01;
                    end
                end else begin
                    dir_down_q <= 1'b0;
                    count_q <= at_top ? VAL_BOTTOM : count_q + 8'h01;
                end
            end
        end
    end

    // compare levels: immediate in non-pwm, double-buffered in pwm
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cmp_a_q <= RESET_BYTE;
            cmp_b_q <= RESET_BYTE;
        end else if (!pwm || (tick && is_phase(mode) && at_top && !dir_down_q)
                     || (tick && is_fast(mode) && at_top)) begin
            cmp_a_q <= buf_a_q;
            cmp_b_q <= buf_b_q;
        end
    end

    // overflow event point per mode
    logic ovf;
    always_comb begin
        case (mode)
            TWC_PC_FF, TWC_PC_TOPA: ovf = tick && dir_down_q && at_bot;
            TWC_FAST_TOPA: ovf = tick && at_top;
            TWC_RES4, TWC_RES6: ovf = 1'b0;
            default: ovf = tick && count_q == VAL_MAX;
        endcase
    end

    // ------------------------------------------------------------
    // waveform outputs
    // ------------------------------------------------------------
    function automatic logic wave_next(input logic cur, input logic [1:0] act,
                                       input twc_mode_type m, input logic match,
                                       input logic frc, input logic at_t, input logic at_b,
                                       input logic at_lvl_top, input logic dn, input logic tk);
        logic r;
        r = cur;
        if (m == TWC_RES4 || m == TWC_RES6) begin
            r = cur;
        end else if (is_fast(m)) begin
            if (act[1]) begin
                if (match && !at_lvl_top) r = act[0];
                else if (tk && at_t) r = ~act[0];
            end
        end else if (is_phase(m)) begin
            if (act[1]) begin
                if (at_lvl_top) begin
                    if (tk && at_t && !dn) r = ~act[0];
                end else if (match) begin
                    r = dn ? ~act[0] : act[0];
                end
            end
        end else if (match || frc) begin
            case (act)
                2'h1: r = ~cur;
                2'h2: r = 1'b0;
                2'h3: r = 1'b1;
                default: r = cur;
            endcase
        end
        return r;
    endfunction : wave_next

    logic wave_a, wave_b;
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wave_a <= 1'b0;
            wave_b <= 1'b0;
        end else begin
            // fast pwm sets/clears on entering bottom: at_t here marks the wrap
            wave_a <= wave_next(wave_a, cfg.output_a_action, mode, m_a, force_a, at_top,
                                at_bot, cmp_a_q == top, dir_down_q, tick);
            wave_b <= wave_next(wave_b, cfg.output_b_action, mode, m_b, force_b,
                                at_top, at_bot, cmp_b_q == top, dir_down_q,
                                tick);
        end
    end
    assign o_compare_output_a = wave_a;
    assign o_compare_output_b = wave_b;

    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_pin_override_a <= 1'b0;
            o_pin_override_b <= 1'b0;
            o_events <= '0;
        end else begin
            o_pin_override_a <= |ctrl_a_q[ACT_A_LSB +: 2];
            o_pin_override_b <= |ctrl_a_q[ACT_B_LSB +: 2];
            o_events.overflow <= ovf;
            o_events.match_a <= m_a;
            o_events.match_b <= m_b;
        end
    end
    // ------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
            o_arready <= 1'b1;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_arready <= 1'b0;
            o_rresp <= RESP_OKAY;
            case (i_araddr)
                ADDR_CTRL_A: o_rdata <= {24'h000000, ctrl_a_q & CTRL_A_WMASK};
                ADDR_CTRL_B: o_rdata <= {24'h000000, ctrl_b_q & CTRL_B_RMASK};
                ADDR_COUNT: o_rdata <= {24'h000000, count_q};
                ADDR_CMP_A: o_rdata <= {24'h000000, buf_a_q};
                ADDR_CMP_B: o_rdata <= {24'h000000, buf_b_q};
                ADDR_STATUS: o_rdata <= {29'h0, dir_down_q, wave_b, wave_a};
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_force_no_flag: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        force_a && !m_a |=> !o_events.match_a)
        else $error("forced compare raised a match event");
    a_res_ctrl_a: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        o_rvalid && $past(i_araddr) == ADDR_CTRL_A && $past(i_arvalid && o_arready)
        |-> o_rdata[3:2] == 2'h0)
        else $error("reserved control bits not zero");
    a_stop_count: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        cfg.clock_select_field == 3'h0 && !wr_cnt && $stable(ctrl_b_q) |=> $stable(count_q))
        else $error("counter moved while stopped");
    a_write_block: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        wr_cnt |=> !m_a && !m_b)
        else $error("match not blocked after counter write");
    a_override_b: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        $changed(ctrl_a_q) |=> o_pin_override_b == |$past(ctrl_a_q[5:4]))
        else $error("pin takeover wrong");
    a_toggle_b: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        mode == TWC_NORMAL && cfg.output_b_action == 2'h1 && m_b |=> wave_b != $past(wave_b))
        else $error("toggle on match missing");
    a_top_wrap: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        tick && !wr_cnt && mode == TWC_NORMAL && count_q == VAL_MAX |=> count_q == 8'h00)
        else $error("normal mode did not wrap");
    a_fast_bottom: assert property (@(posedge i_clk) disable iff (!rst_n_q)
        mode == TWC_FAST_FF && cfg.output_b_action == 2'h2 && tick && at_top && !m_b
        |=> wave_b)
        else $error("non-inverting set at bottom missing");

endmodule : twc_timer8

// ==== tb/test_timer8_waveform_control.sv ====
`timescale 1ns/1ps
module test_timer8_waveform_control;
    import twc_pkg::*;
    logic i_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rv;
    logic [3:0] i_wstrb;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp, rr;
    logic o_compare_output_a, o_pin_override_a, o_compare_output_b, o_pin_override_b;
    twc_evt_type o_events;
    int error_cnt = 0;
    int checked = 0;
    int ev_cnt [3];
    int n;

    twc_timer8 dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
        .o_compare_output_a(o_compare_output_a), .o_pin_override_a(o_pin_override_a),
        .o_compare_output_b(o_compare_output_b), .o_pin_override_b(o_pin_override_b),
        .o_events(o_events));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // counts every event pulse, index 2 overflow, 1 match a, 0 match b
    always @(posedge i_clk) begin
        for (int k = 0; k < 3; k++) begin
            if (o_events[k] !== 1'b0) ev_cnt[k]++;
        end
    end

    // ------------------------------------------------------------
    // bus and helper tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= {24'h0, d};
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end while (o_bvalid !== 1'b1);
        rr = o_bresp;
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end while (o_rvalid !== 1'b1);
        rv = o_rdata;
        rr = o_rresp;
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask : rd

    task automatic wev(input int b);
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_events[b] !== 1'b1 && n < 20000);
        if (o_events[b] !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED event %0d expected 1 seen 0", b);
        end
    endtask : wev

    // stops the timer, loads the counter, then sets mode and clock
    task automatic cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] cnt);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_COUNT, cnt);
        wr(ADDR_CTRL_A, ca);
        wr(ADDR_CTRL_B, cb);
    endtask : cfg

    task automatic per(input logic [7:0] ca, input logic [7:0] cb, input int b, input int e);
        cfg(ca, cb, 8'h00);
        wev(b);
        wev(b);
        chk("event period", e, n);
    endtask : per

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        for (int k = 0; k < 5; k++) begin
            rd(8'(4 * k));
            chk("reset value", 32'h0, rv);
        end
        wr(ADDR_CTRL_A, 8'hFF);
        rd(ADDR_CTRL_A);
        chk("ctrl a readback", 32'hF3, rv);
        wr(ADDR_CTRL_B, 8'h38);
        rd(ADDR_CTRL_B);
        chk("ctrl b readback", 32'h08, rv);
        cfg(8'h00, 8'h00, 8'h5A);
        rd(ADDR_COUNT);
        chk("counter readback", 32'h5A, rv);
        rd(8'h18);
        chk("unmapped read resp", RESP_SLVERR, rr);
        chk("unmapped read data", 32'h0, rv);
        wr(8'h18, 8'h11);
        chk("unmapped write resp", RESP_SLVERR, rr);
        $display("test regs finished");
    endtask : t_regs

    task automatic t_force();
        logic [1:0] a;
        cfg(8'h00, 8'h00, 8'h00);
        ev_cnt = '{0, 0, 0};
        for (int k = 0; k < 4; k++) begin
            a = (k < 2) ? 2'(3 - k) : 2'h1;
            wr(ADDR_CTRL_A, {2'h0, a, 4'h0});
            wr(ADDR_CTRL_B, 8'h40);
            repeat (3) @(posedge i_clk);
            chk("override b", 1'b1, o_pin_override_b);
            chk("forced level b", 32'(k % 2 == 0), o_compare_output_b);
        end
        rd(ADDR_CTRL_B);
        chk("force bits read", 32'h0, rv);
        wr(ADDR_CMP_A, 8'h05);
        cfg(8'hC2, 8'h00, 8'h05);
        wr(ADDR_CTRL_B, 8'h80);
        repeat (3) @(posedge i_clk);
        chk("forced level a", 1'b1, o_compare_output_a);
        chk("override a", 1'b1, o_pin_override_a);
        rd(ADDR_COUNT);
        chk("counter after force", 32'h05, rv);
        chk("events after force", 0, ev_cnt[0] + ev_cnt[1] + ev_cnt[2]);
        wr(ADDR_CTRL_A, 8'h00);
        repeat (3) @(posedge i_clk);
        chk("override b off", 1'b0, o_pin_override_b);
        chk("override a off", 1'b0, o_pin_override_a);
        $display("test force finished");
    endtask : t_force

    task automatic t_count();
        wr(ADDR_CMP_B, 8'h10);
        ev_cnt = '{0, 0, 0};
        repeat (300) @(posedge i_clk);
        chk("events while stopped", 0, ev_cnt[2]);
        cfg(8'h00, 8'h01, 8'h00);
        ev_cnt[0] = 0;
        wr(ADDR_COUNT, 8'h10);
        repeat (20) @(posedge i_clk);
        chk("match after counter write", 0, ev_cnt[0]);
        // reserved mode 4 with the clock running: counter wraps, no overflow
        cfg(8'h10, 8'h09, 8'h00);
        ev_cnt[2] = 0;
        repeat (300) @(posedge i_clk);
        chk("reserved mode overflow", 0, ev_cnt[2]);
        $display("test counter finished");
    endtask : t_count

    task automatic t_pwm();
        logic [1:0] a;
        int hi;
        cfg(8'h00, 8'h00, 8'h00);
        wr(ADDR_CMP_B, 8'h40);
        for (int k = 0; k < 2; k++) begin
            a = 2'(2 + k);
            cfg({2'h0, a, 4'h3}, 8'h01, 8'h00);
            wev(0);
            repeat (2) @(posedge i_clk);
            chk("fast level at match", 32'(k), o_compare_output_b);
            wev(2);
            repeat (2) @(posedge i_clk);
            chk("fast level at bottom", 32'(1 - k), o_compare_output_b);
            cfg({2'h0, a, 4'h1}, 8'h01, 8'h00);
            for (int j = 0; j < 2; j++) begin
                wev(0);
                rd(ADDR_STATUS);
                chk("phase level", 32'(rv[2] ^ k[0]), o_compare_output_b);
            end
        end
        cfg(8'h00, 8'h00, 8'h00);
        wr(ADDR_CMP_A, 8'h09);
        wr(ADDR_CMP_B, 8'h09);
        // level B equals TOP: fast inverting stays low, phase non-inverting stays high
        for (int j = 0; j < 2; j++) begin
            cfg(j ? 8'h21 : 8'h33, 8'h09, 8'h00);
            wev(2);
            hi = 0;
            repeat (2) @(posedge i_clk);
            repeat (40) begin
                @(posedge i_clk);
                if (o_compare_output_b !== 1'(j)) hi++;
            end
            chk("level at top compare", 0, hi);
        end
        $display("test pwm finished");
    endtask : t_pwm

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        #1_000_000;
        error_cnt++;
        complete_run();
    end

    initial begin
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        i_awaddr = 8'h00;
        i_araddr = 8'h00;
        i_wdata = 32'h0;
        i_wstrb = 4'hF;
        i_reset_n = 1'b0;
        repeat (3) @(posedge i_clk);
        i_reset_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_regs();
        t_force();
        t_count();
        t_pwm();
        cfg(8'h00, 8'h00, 8'h00);
        wr(ADDR_CMP_A, 8'h09);
        per(8'h00, 8'h01, 2, 256);
        per(8'h00, 8'h02, 2, 2048);
        per(8'h00, 8'h03, 2, 8192);
        per(8'h10, 8'h01, 0, 256);
        per(8'h02, 8'h01, 1, 10);
        per(8'h02, 8'h04, 1, 640);
        per(8'h02, 8'h05, 1, 1280);
        per(8'h02, 8'h06, 1, 2560);
        per(8'h02, 8'h07, 1, 10240);
        per(8'h03, 8'h01, 2, 256);
        per(8'h03, 8'h09, 2, 10);
        per(8'h01, 8'h01, 2, 510);
        per(8'h01, 8'h09, 2, 18);
        $display("test periods finished");
        complete_run();
    end
endmodule : test_timer8_waveform_control
